/* File: hdl/rms_defs.vh */
`ifndef RMS_DEFS_VH
`define RMS_DEFS_VH

// Register addresses on the serial register interface
`define RMS_ADDR_DEV_STATE 7'h02
`define RMS_ADDR_FLAGS_ONE 7'h03
`define RMS_ADDR_FLAGS_TWO 7'h04
`define RMS_ADDR_MASK_ONE 7'h05
`define RMS_ADDR_MASK_TWO 7'h06
`define RMS_ADDR_MODE 7'h07
`define RMS_ADDR_CAL_CTRL 7'h0C

// Mode control bits
`define RMS_MODE_XTAL_KEEP 0
`define RMS_MODE_SYNTH_KEEP 1
`define RMS_MODE_TX_REQ 3
`define RMS_MODE_LBD_EN 5
`define RMS_MODE_WUT_EN 6
`define RMS_MODE_SW_RESET 7

// Calibration control bits
`define RMS_CAL_VCO_EN 0

// Event flag bit positions
`define RMS_EV1_PKT_SENT 2
`define RMS_EV2_CHIP_READY 1
`define RMS_EV2_POWER_ON 0

// Implemented bits of the event registers
`define RMS_EV1_VALID 8'hEC
`define RMS_EV2_VALID 8'h0F

// Reset values
`define RMS_MASK_ONE_RST 8'h00
`define RMS_MASK_TWO_RST 8'h01
`define RMS_MODE_RST 8'h01
`define RMS_CAL_CTRL_RST 8'h01

// Chip power state codes in the device state register
`define RMS_CPS_IDLE 2'h0
`define RMS_CPS_TX 2'h1

// Timing, in microseconds, and the clock period in nanoseconds
`define RMS_CLK_PERIOD_NS 10
`define RMS_POR_TIME_US 16000
`define RMS_XTAL_TIME_US 600
`define RMS_PLL_BIAS_TIME_US 50
`define RMS_VCO_CAL_TIME_US 50
`define RMS_PLL_SETTLE_TIME_US 100
`define RMS_PA_RAMP_TIME_US 5
`define RMS_PKT_TIME_US 100

// Least time in cycles, rounded up
`define RMS_US_TO_CYC(us) ((((us) * 1000) + `RMS_CLK_PERIOD_NS - 1) / `RMS_CLK_PERIOD_NS)

`endif

/* File: hdl/rms_sync.v */
`timescale 1ns/1ns
// Two-flop synchroniser, one pair per bit
module rms_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Asynchronous inputs and their synchronised copies
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q; // First stage, read only by the second
      reg sync_q; // Second stage, safe to use
      // Two flops per bit
      always @(posedge clk) begin
        if (rst) begin
          meta_q <= RESET_VAL[i];
          sync_q <= RESET_VAL[i];
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule // rms_sync

/* File: hdl/rms_mode_seq.v */
`timescale 1ns/1ns
`include "rms_defs.vh"
module rms_mode_seq #(
  parameter POR_CYC = `RMS_US_TO_CYC(`RMS_POR_TIME_US),
  parameter XTAL_CYC = `RMS_US_TO_CYC(`RMS_XTAL_TIME_US),
  parameter PLL_BIAS_CYC = `RMS_US_TO_CYC(`RMS_PLL_BIAS_TIME_US),
  parameter VCO_CAL_CYC = `RMS_US_TO_CYC(`RMS_VCO_CAL_TIME_US),
  parameter SETTLE_CYC = `RMS_US_TO_CYC(`RMS_PLL_SETTLE_TIME_US),
  parameter RAMP_CYC = `RMS_US_TO_CYC(`RMS_PA_RAMP_TIME_US),
  parameter PKT_CYC = `RMS_US_TO_CYC(`RMS_PKT_TIME_US)
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Pins from the host
  input wire SHUTDOWN_PIN,
  input wire SCLK,
  input wire SDI,
  input wire SEL_N,
  // Serial read data
  output reg SDO,
  output reg SDO_OE,
  // Interrupt line
  output reg INTERRUPT_REQUEST_LOW,
  // Event pulses and status levels from neighbouring logic
  input wire [7:0] EVENT_ONE_IN,
  input wire [7:0] EVENT_TWO_IN,
  input wire FIFO_OVERFLOW,
  input wire FIFO_UNDERFLOW,
  input wire FREQ_ERROR,
  // Power and block enables
  output reg MAIN_REG_ON,
  output reg LOW_POWER_REGULATOR_ON,
  output reg XTAL_ON,
  output reg SYNTH_ON,
  output reg VCO_CAL_ON,
  output reg PA_ON,
  output reg WUT_ON,
  output reg LBD_ON,
  output reg TX_SEND
);

  // Sequencer states
  localparam [3:0] S_SHUT = 4'h0;
  localparam [3:0] S_POR = 4'h1;
  localparam [3:0] S_IDLE = 4'h2;
  localparam [3:0] S_LDO = 4'h3;
  localparam [3:0] S_XTAL = 4'h4;
  localparam [3:0] S_PLL = 4'h5;
  localparam [3:0] S_CAL = 4'h6;
  localparam [3:0] S_SETTLE = 4'h7;
  localparam [3:0] S_RAMP = 4'h8;
  localparam [3:0] S_SEND = 4'h9;

  // Synchronised pins
  wire [3:0] pins_s;
  wire sdn_s = pins_s[3];
  wire sclk_s = pins_s[2];
  wire sdi_s = pins_s[1];
  wire sel_n_s = pins_s[0];

  rms_sync #(.WIDTH(4), .RESET_VAL(4'h9)) u_sync (
    .clk(CLK),
    .rst(RST),
    .async_in({SHUTDOWN_PIN, SCLK, SDI, SEL_N}),
    .sync_out(pins_s)
  );

  // Sequencer state
  reg [3:0] state_q;
  reg [23:0] cnt_q;
  reg tx_done_q; // One cycle after the packet step ends
  reg por_done_q; // Power-on finished pulse
  reg xtal_rdy_q; // Crystal ready pulse
  // Register file
  reg [7:0] flags1_q;
  reg [7:0] flags2_q;
  reg [7:0] mask1_q;
  reg [7:0] mask2_q;
  reg [7:0] mode_q;
  reg [7:0] cal_q;
  reg sw_rst_q; // Software reset pulse
  // Serial interface
  reg sclk_prev_q;
  reg [2:0] bit_cnt_q;
  reg [7:0] shin_q;
  reg [7:0] shout_q;
  reg [6:0] addr_q;
  reg hdr_q; // Address byte taken
  reg write_q; // Transaction is a write
  reg [1:0] clr_pend_q; // Flags register loaded for shifting, cleared at the first clock of its byte

  // Shutdown, or power-on not yet finished, blocks the serial interface; reset, shutdown or a software reset clears the registers
  wire dev_rst = RST | sdn_s;
  wire reg_rst = dev_rst | sw_rst_q;
  wire spi_live = (state_q != S_SHUT) && (state_q != S_POR);
  wire sel = ~sel_n_s & spi_live;
  wire rise = sclk_s & ~sclk_prev_q;
  wire fall = ~sclk_s & sclk_prev_q;
  wire [7:0] byte_w = {shin_q[6:0], sdi_s};
  wire last = sel & rise & (bit_cnt_q == 3'h7);
  wire [6:0] addr_inc = addr_q + 7'h01;
  wire [6:0] load_addr = hdr_q ? addr_inc : byte_w[6:0];
  wire do_load = last & (hdr_q ? ~write_q : ~byte_w[7]);
  wire do_write = last & hdr_q & write_q;
  // A prefetched burst byte that the host never clocks must not lose its flags
  wire clr_go = sel & rise & ~do_load;

  // Mode decode
  wire keep_xtal = mode_q[`RMS_MODE_XTAL_KEEP] | mode_q[`RMS_MODE_SYNTH_KEEP];
  wire keep_pll = mode_q[`RMS_MODE_SYNTH_KEEP];
  wire low_power_only = ~(keep_xtal | mode_q[`RMS_MODE_LBD_EN]);
  wire in_tx = (state_q >= S_LDO) && (state_q <= S_SEND);

  // Read multiplexer, with read-clear masks
  reg [7:0] rd_data;
  reg [7:0] clr1;
  reg [7:0] clr2;
  always @* begin
    rd_data = 8'h00;
    clr1 = (clr_go & clr_pend_q[0]) ? mask1_q : 8'h00;
    clr2 = (clr_go & clr_pend_q[1]) ? mask2_q : 8'h00;
    case (load_addr)
      `RMS_ADDR_DEV_STATE: rd_data = {FIFO_OVERFLOW, FIFO_UNDERFLOW, 2'h0, FREQ_ERROR, 1'b0,
                                      in_tx ? `RMS_CPS_TX : `RMS_CPS_IDLE};
      `RMS_ADDR_FLAGS_ONE: rd_data = flags1_q;
      `RMS_ADDR_FLAGS_TWO: rd_data = flags2_q;
      `RMS_ADDR_MASK_ONE: rd_data = mask1_q;
      `RMS_ADDR_MASK_TWO: rd_data = mask2_q;
      `RMS_ADDR_MODE: rd_data = mode_q;
      `RMS_ADDR_CAL_CTRL: rd_data = cal_q;
      default: rd_data = 8'h00;
    endcase
  end

  // Event sets: hardware events plus outside pulses, reserved bits dropped
  wire [7:0] set1 = (EVENT_ONE_IN | ({7'h00, tx_done_q} << `RMS_EV1_PKT_SENT)) & `RMS_EV1_VALID;
  wire [7:0] set2 = (EVENT_TWO_IN | ({7'h00, xtal_rdy_q} << `RMS_EV2_CHIP_READY)
                    | ({7'h00, por_done_q} << `RMS_EV2_POWER_ON)) & `RMS_EV2_VALID;

  // Serial shift logic: sample on rising SCLK, drive on falling SCLK
  always @(posedge CLK) begin
    if (dev_rst) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= 3'h0;
      shin_q <= 8'h00;
      shout_q <= 8'h00;
      addr_q <= 7'h00;
      hdr_q <= 1'b0;
      write_q <= 1'b0;
      clr_pend_q <= 2'h0;
      SDO <= 1'b1;
      SDO_OE <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      SDO_OE <= sel;
      if (!sel) begin
        // Deselected: frame ends, line idles high
        bit_cnt_q <= 3'h0;
        hdr_q <= 1'b0;
        write_q <= 1'b0;
        clr_pend_q <= 2'h0;
        SDO <= 1'b1;
      end else begin
        // Read-clear waits for the first clock of the byte that carries the flags
        if (do_load) begin
          clr_pend_q <= {load_addr == `RMS_ADDR_FLAGS_TWO, load_addr == `RMS_ADDR_FLAGS_ONE};
        end else if (rise) begin
          clr_pend_q <= 2'h0;
        end
        if (rise) begin
          shin_q <= byte_w;
          bit_cnt_q <= bit_cnt_q + 3'h1;
        end
        if (last) begin
          // Header byte, then data bytes with burst address increment
          if (!hdr_q) begin
            hdr_q <= 1'b1;
            write_q <= byte_w[7];
            addr_q <= byte_w[6:0];
          end else begin
            addr_q <= addr_inc;
          end
        end
        if (do_load) begin
          shout_q <= rd_data;
        end else if (fall && hdr_q && !write_q) begin
          SDO <= shout_q[7];
          shout_q <= {shout_q[6:0], 1'b0};
        end
      end
    end
  end

  // Register file: set wins over read-clear
  always @(posedge CLK) begin
    if (reg_rst) begin
      flags1_q <= 8'h00;
      flags2_q <= 8'h00;
      mask1_q <= `RMS_MASK_ONE_RST;
      mask2_q <= `RMS_MASK_TWO_RST;
      mode_q <= `RMS_MODE_RST;
      cal_q <= `RMS_CAL_CTRL_RST;
      sw_rst_q <= 1'b0;
    end else begin
      flags1_q <= (flags1_q & ~clr1) | set1;
      flags2_q <= (flags2_q & ~clr2) | set2;
      sw_rst_q <= 1'b0;
      if (do_write) begin
        case (addr_q)
          `RMS_ADDR_MASK_ONE: mask1_q <= byte_w & `RMS_EV1_VALID;
          `RMS_ADDR_MASK_TWO: mask2_q <= byte_w & `RMS_EV2_VALID;
          `RMS_ADDR_MODE: begin
            mode_q <= {1'b0, byte_w[6:0]};
            sw_rst_q <= byte_w[`RMS_MODE_SW_RESET];
          end
          `RMS_ADDR_CAL_CTRL: cal_q <= byte_w & 8'h01;
          default: sw_rst_q <= 1'b0;
        endcase
      end else if (tx_done_q) begin
        // Request drops once the packet is out
        mode_q[`RMS_MODE_TX_REQ] <= 1'b0;
      end
    end
  end

  // Radio sequencer
  always @(posedge CLK) begin
    if (RST || sdn_s) begin
      state_q <= S_SHUT;
      cnt_q <= 24'h000000;
      tx_done_q <= 1'b0;
      por_done_q <= 1'b0;
      xtal_rdy_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      por_done_q <= 1'b0;
      xtal_rdy_q <= 1'b0;
      if (cnt_q != 24'h000000) begin
        cnt_q <= cnt_q - 24'h000001;
      end
      case (state_q)
        S_SHUT: begin
          // Pin low seen after reset: start the power-on delay
          state_q <= S_POR;
          cnt_q <= POR_CYC[23:0] - 24'h000001;
        end
        S_POR: begin
          if (cnt_q == 24'h000000) begin
            state_q <= S_IDLE;
            por_done_q <= 1'b1;
          end
        end
        S_IDLE: begin
          if (sw_rst_q) begin
            state_q <= S_IDLE;
          end else if (mode_q[`RMS_MODE_TX_REQ]) begin
            state_q <= S_LDO;
          end
        end
        S_LDO: begin
          // Regulators up; skip steps the idle mode already covers
          if (keep_pll) begin
            state_q <= S_RAMP;
            cnt_q <= RAMP_CYC[23:0] - 24'h000001;
          end else if (keep_xtal) begin
            state_q <= S_PLL;
            cnt_q <= PLL_BIAS_CYC[23:0] - 24'h000001;
          end else begin
            state_q <= S_XTAL;
            cnt_q <= XTAL_CYC[23:0] - 24'h000001;
          end
        end
        S_XTAL: begin
          if (cnt_q == 24'h000000) begin
            state_q <= S_PLL;
            xtal_rdy_q <= 1'b1;
            cnt_q <= PLL_BIAS_CYC[23:0] - 24'h000001;
          end
        end
        S_PLL: begin
          // Synthesizer just switched on: calibrate unless disabled
          if (cnt_q == 24'h000000) begin
            if (cal_q[`RMS_CAL_VCO_EN]) begin
              state_q <= S_CAL;
              cnt_q <= VCO_CAL_CYC[23:0] - 24'h000001;
            end else begin
              state_q <= S_SETTLE;
              cnt_q <= SETTLE_CYC[23:0] - 24'h000001;
            end
          end
        end
        S_CAL: begin
          if (cnt_q == 24'h000000) begin
            state_q <= S_SETTLE;
            cnt_q <= SETTLE_CYC[23:0] - 24'h000001;
          end
        end
        S_SETTLE: begin
          if (cnt_q == 24'h000000) begin
            state_q <= S_RAMP;
            cnt_q <= RAMP_CYC[23:0] - 24'h000001;
          end
        end
        S_RAMP: begin
          if (cnt_q == 24'h000000) begin
            state_q <= S_SEND;
            cnt_q <= PKT_CYC[23:0] - 24'h000001;
          end
        end
        S_SEND: begin
          if (cnt_q == 24'h000000) begin
            state_q <= S_IDLE;
            tx_done_q <= 1'b1;
          end
        end
        default: state_q <= S_SHUT;
      endcase
    end
  end

  // Registered block enables and interrupt line
  always @(posedge CLK) begin
    if (dev_rst) begin
      MAIN_REG_ON <= 1'b0;
      LOW_POWER_REGULATOR_ON <= 1'b0;
      XTAL_ON <= 1'b0;
      SYNTH_ON <= 1'b0;
      VCO_CAL_ON <= 1'b0;
      PA_ON <= 1'b0;
      WUT_ON <= 1'b0;
      LBD_ON <= 1'b0;
      TX_SEND <= 1'b0;
      INTERRUPT_REQUEST_LOW <= 1'b1;
    end else begin
      LOW_POWER_REGULATOR_ON <= (state_q != S_SHUT);
      MAIN_REG_ON <= (state_q == S_POR) || in_tx || ((state_q == S_IDLE) && !low_power_only);
      XTAL_ON <= ((state_q == S_IDLE) && keep_xtal) || (in_tx && (state_q != S_LDO));
      SYNTH_ON <= ((state_q == S_IDLE) && keep_pll) || (state_q >= S_PLL && state_q <= S_SEND);
      VCO_CAL_ON <= (state_q == S_CAL);
      PA_ON <= (state_q == S_RAMP) || (state_q == S_SEND);
      TX_SEND <= (state_q == S_SEND);
      WUT_ON <= spi_live && (mode_q[`RMS_MODE_WUT_EN] | mode_q[`RMS_MODE_LBD_EN]);
      LBD_ON <= spi_live && mode_q[`RMS_MODE_LBD_EN];
      // Low while any enabled flag stands; read-clear releases it
      INTERRUPT_REQUEST_LOW <= ~(|(flags1_q & mask1_q) | |(flags2_q & mask2_q));
    end
  end

endmodule // rms_mode_seq

/* File: testbench/rms_mode_seq_props.sv */
`timescale 1ns/1ns
// Pin-level checks of the sequencer
module rms_props (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Host pins
  input wire SHUTDOWN_PIN,
  input wire SEL_N,
  input wire SDO_OE,
  input wire INTERRUPT_REQUEST_LOW,
  // Enables
  input wire MAIN_REG_ON,
  input wire LOW_POWER_REGULATOR_ON,
  input wire XTAL_ON,
  input wire SYNTH_ON,
  input wire VCO_CAL_ON,
  input wire PA_ON,
  input wire LBD_ON,
  input wire WUT_ON,
  input wire TX_SEND
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Amplifier ramp ahead of the packet
  sequence s_ramp;
    (PA_ON && !TX_SEND) [*8];
  endsequence
  // Packet send window
  sequence s_send;
    TX_SEND [*8];
  endsequence
  chk_shut_off: assert property (SHUTDOWN_PIN [*4] |-> !(LOW_POWER_REGULATOR_ON || MAIN_REG_ON || SDO_OE))
    else $error("block on in shutdown");
  chk_lp_on: assert property (!SHUTDOWN_PIN [*8] |-> LOW_POWER_REGULATOR_ON)
    else $error("low power regulator off");
  chk_main_reg: assert property ((XTAL_ON || LBD_ON || SYNTH_ON) |-> MAIN_REG_ON)
    else $error("main regulator off");
  chk_synth_xtal: assert property (SYNTH_ON |-> XTAL_ON)
    else $error("synth without crystal");
  chk_lbd_wut: assert property (LBD_ON |-> WUT_ON)
    else $error("sensor without timer");
  chk_cal_order: assert property (VCO_CAL_ON |-> SYNTH_ON && !PA_ON && $past(SYNTH_ON))
    else $error("calibration out of order");
  chk_ramp_send: assert property ($rose(PA_ON) |-> s_ramp ##[1:1000] TX_SEND)
    else $error("ramp then send broken");
  chk_send_end: assert property ($rose(TX_SEND) |-> s_send ##[1:1000] !(TX_SEND || PA_ON))
    else $error("send never ends");
  chk_irq_read: assert property ($rose(INTERRUPT_REQUEST_LOW) |->
    !$past(SEL_N, 3) || $past(SHUTDOWN_PIN, 2) || SHUTDOWN_PIN)
    else $error("interrupt released without access");
endmodule // rms_props

bind rms_mode_seq rms_props u_props (.CLK(CLK), .RST(RST), .SHUTDOWN_PIN(SHUTDOWN_PIN), .SEL_N(SEL_N),
  .SDO_OE(SDO_OE), .INTERRUPT_REQUEST_LOW(INTERRUPT_REQUEST_LOW), .MAIN_REG_ON(MAIN_REG_ON),
  .LOW_POWER_REGULATOR_ON(LOW_POWER_REGULATOR_ON), .XTAL_ON(XTAL_ON), .SYNTH_ON(SYNTH_ON),
  .VCO_CAL_ON(VCO_CAL_ON), .PA_ON(PA_ON), .LBD_ON(LBD_ON), .WUT_ON(WUT_ON), .TX_SEND(TX_SEND));

/* File: testbench/rms_host.sv */
`timescale 1ns/1ns
// Host controller on the serial pins
module rms_host (
  // Serial pins
  output logic sclk,
  output logic sdi,
  output logic sel_n,
  input wire sdo
);
  // Link clock idles low between frames
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    sel_n = 1'b1;
  end
  // One 16-bit frame, MSB first, read bits taken at rises
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    int i;
    r = 8'h00;
    sel_n = 1'b0;
    #63;
    for (i = 15; i >= 0; i--) begin
      sdi = w[i];
      #62 sclk = 1'b1;
      if (i < 8) r[i] = sdo;
      #63 sclk = 1'b0;
    end
    #63 sel_n = 1'b1;
    sdi = ~sdi;  // Released line shows the inverse
    #200;
  endtask
  // Event registers read after power-up or on a low line
  task automatic read_events(output logic [7:0] f1, output logic [7:0] f2);
    xfer(16'h0300, f1);
    xfer(16'h0400, f2);
  endtask
endmodule // rms_host

/* File: testbench/rms_mode_seq_bench.sv */
`timescale 1ns/1ns
// Self-checking bench of the mode sequencer
module rms_mode_seq_bench;
  logic clk, rst, shdn, sclk, sdi, sel_n, sdo, oe, irq_n, ovf, unf, ferr;
  logic main_on, lp_on, xt_on, syn_on, cal_on, pa_on, wut_on, lbd_on, send;
  logic [7:0] ev1, ev2, rv, f1, f2;
  int fails, total_checks, cyc, c_syn, c_cal, c_ramp, c_send, oe_seen;
  // Device with short step counts
  rms_mode_seq #(.POR_CYC(20), .XTAL_CYC(20), .PLL_BIAS_CYC(20), .VCO_CAL_CYC(20),
    .SETTLE_CYC(20), .RAMP_CYC(20), .PKT_CYC(20)) u_dut (.CLK(clk), .RST(rst),
    .SHUTDOWN_PIN(shdn), .SCLK(sclk), .SDI(sdi), .SEL_N(sel_n), .SDO(sdo), .SDO_OE(oe),
    .INTERRUPT_REQUEST_LOW(irq_n), .EVENT_ONE_IN(ev1), .EVENT_TWO_IN(ev2),
    .FIFO_OVERFLOW(ovf), .FIFO_UNDERFLOW(unf), .FREQ_ERROR(ferr), .MAIN_REG_ON(main_on),
    .LOW_POWER_REGULATOR_ON(lp_on), .XTAL_ON(xt_on), .SYNTH_ON(syn_on), .VCO_CAL_ON(cal_on),
    .PA_ON(pa_on), .WUT_ON(wut_on), .LBD_ON(lbd_on), .TX_SEND(send));
  rms_host u_host (.sclk(sclk), .sdi(sdi), .sel_n(sel_n), .sdo(sdo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Step counters and timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (syn_on && !pa_on) c_syn <= c_syn + 1;
    if (cal_on) c_cal <= c_cal + 1;
    if (pa_on && !send) c_ramp <= c_ramp + 1;
    if (send) c_send <= c_send + 1;
    if (oe) oe_seen <= 1;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  // Compare and count
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({1'b1, a, d}, rv);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e, input string nm);
    u_host.xfer({1'b0, a, 8'h00}, rv);
    chk(nm, rv, e);
  endtask
  // Power-up defaults and power-on flag
  task t_por();
    chk("irq", {7'h00, irq_n}, 8'h00);
    rd(7'h06, 8'h01, "mask2");
    rd(7'h07, 8'h01, "mode");
    u_host.read_events(f1, f2);
    chk("flags2", f2, 8'h01);
    chk("irq", {7'h00, irq_n}, 8'h01);
  endtask
  // Idle sub-modes and their enables
  task t_modes();
    logic [7:0] m [5] = '{8'h00, 8'h40, 8'h20, 8'h01, 8'h02};
    logic [7:0] e [5] = '{8'h00, 8'h02, 8'h13, 8'h18, 8'h1C};
    for (int i = 0; i < 5; i++) begin
      wr(7'h07, m[i]);
      repeat (10) @(negedge clk);
      chk("enab", {3'h0, main_on, xt_on, syn_on, wut_on, lbd_on}, e[i]);
      rd(7'h07, m[i], "mode");
    end
  endtask
  // Transmit with synthesizer, calibration, ramp and send steps timed
  task t_tx(input logic [7:0] m, input logic [7:0] syn, input logic [7:0] cal);
    @(negedge clk);
    c_syn = 0; c_cal = 0; c_ramp = 0; c_send = 0;
    wr(7'h07, m);
    for (int i = 0; i < 3000 && send !== 1'b1; i++) @(negedge clk);
    for (int i = 0; i < 3000 && (send || pa_on) !== 1'b0; i++) @(negedge clk);
    chk("pll", c_syn[7:0], syn);
    chk("cal", c_cal[7:0], cal);
    chk("ramp", c_ramp[7:0], 8'h14);
    chk("send", c_send[7:0], 8'h14);
    rd(7'h07, m & 8'hF7, "txdone");
    rd(7'h03, 8'h04, "pkt");
    chk("irq", {7'h00, irq_n}, 8'h01);
  endtask
  // Enabling a pending flag, then read-clear
  task t_mask();
    wr(7'h05, 8'h04);
    repeat (4) @(negedge clk);
    chk("irq", {7'h00, irq_n}, 8'h00);
    rd(7'h03, 8'h04, "pkt");
    chk("irq", {7'h00, irq_n}, 8'h01);
    rd(7'h03, 8'h00, "pkt");
    @(posedge clk) ev2 <= 8'h08;
    @(posedge clk) ev2 <= 8'h00;
    rd(7'h04, 8'h0A, "flags2");
    @(posedge clk) ev1 <= 8'h88;
    @(posedge clk) ev1 <= 8'h00;
    repeat (4) @(negedge clk);
    chk("irq", {7'h00, irq_n}, 8'h01);
    rd(7'h03, 8'h88, "flags1");
  endtask
  // Status levels, software reset and shutdown
  task t_reset();
    @(posedge clk) begin
      ovf <= 1'b1;
      unf <= 1'b1;
      ferr <= 1'b1;
    end
    rd(7'h02, 8'hC8, "status");
    @(posedge clk) begin
      ovf <= 1'b0;
      unf <= 1'b0;
      ferr <= 1'b0;
    end
    wr(7'h05, 8'hFF);
    rd(7'h05, 8'hEC, "mask1");
    wr(7'h07, 8'h80);
    rd(7'h05, 8'h00, "mask1");
    rd(7'h07, 8'h01, "mode");
    wr(7'h05, 8'hEC);
    @(posedge clk) shdn <= 1'b1;
    repeat (10) @(negedge clk);
    chk("lp", {7'h00, lp_on}, 8'h00);
    oe_seen = 0;
    rd(7'h05, 8'hFF, "shut");
    chk("oe", oe_seen[7:0], 8'h00);
    @(posedge clk) shdn <= 1'b0;
    repeat (60) @(negedge clk);
    chk("irq", {7'h00, irq_n}, 8'h00);
    rd(7'h05, 8'h00, "mask1");
    rd(7'h07, 8'h01, "mode");
  endtask
  // Verdict
  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1; shdn = 1'b0; ev1 = 8'h00; ev2 = 8'h00; ovf = 1'b0; unf = 1'b0; ferr = 1'b0;
    fails = 0; total_checks = 0; cyc = 0; oe_seen = 0;
    c_syn = 0; c_cal = 0; c_ramp = 0; c_send = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(negedge clk);
    t_por();
    t_modes();
    wr(7'h07, 8'h00);
    t_tx(8'h08, 8'h3C, 8'h14);
    wr(7'h0C, 8'h00);
    wr(7'h07, 8'h01);
    t_tx(8'h09, 8'h28, 8'h00);
    t_mask();
    t_reset();
    end_of_test();
  end
endmodule // rms_mode_seq_bench
